// >>> uart_frame_pkg.sv
// Shared constants and types for the low-energy serial frame block
// Behaviour
// (R01) One low start bit, one bit period
// (R02) Eight or nine data bits, optional parity
// (R03) Data bits sent and received LSB first
// (R04) High stop bits, one or two
// (R05) Format taken from width, stop, parity controls
// (R06) Both ends must agree on frame format
// (R07) Invert control flips the whole frame
// (R08) Change inversion only with receiver off
// (R09) Hardware inserts and checks parity bit
// (R10) Even or odd count of high bits
// (R11) Parity codes: 00 none, 10 even, 11 odd
// (R12) Divider: 7-bit integer, 5-bit fraction
// (R13) Baud equals clock over one plus divider/256
// (R14) Fraction at bits 7:3, integer 14:8
// (R15) 300 to 9600 baud at 32.768 kHz
// (R16) Timing advances only on module clock edges
// (R17) Fraction accumulates, overflow stretches one bit
package uart_frame_pkg;
    localparam int MCLK_HZ = 100_000_000;
    localparam int LF_CLK_HZ = 32_768;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 9600;
    // Divider field layout
    localparam int DIV_W = 15;
    localparam int DIV_INT_HI = 14;
    localparam int DIV_INT_LO = 8;
    localparam int DIV_FRAC_HI = 7;
    localparam int DIV_FRAC_LO = 3;
    localparam int DIV_INT_W = DIV_INT_HI - DIV_INT_LO + 1;
    localparam int DIV_FRAC_W = DIV_FRAC_HI - DIV_FRAC_LO + 1;
    localparam int BAUD_CNT_W = DIV_INT_W + 1;
    // Parity mode codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_RSVD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    // Frame sizes
    localparam int WORD_W = 9;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] LAST_IDX_8 = 4'h7;
    localparam logic [IDX_W-1:0] LAST_IDX_9 = 4'h8;
    localparam logic [WORD_W-1:0] WORD_RESET = 9'h000;
    localparam logic [BAUD_CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [DIV_FRAC_W-1:0] ACC_RESET = 5'h00;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
    } tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } rx_state_type;
endpackage : uart_frame_pkg

// >>> uart_baud_gen.sv
// Fractional bit-period generator stepped by low-frequency clock ticks
`timescale 1ns/10ps
module uart_baud_gen (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Timing control
    input wire logic i_lf_tick,
    input wire logic i_restart,
    input wire logic [uart_frame_pkg::DIV_INT_W-1:0] i_div_int,
    input wire logic [uart_frame_pkg::DIV_FRAC_W-1:0] i_div_frac,
    // Bit timing strobes
    output logic o_bit_mid,
    output logic o_bit_end
);
    import uart_frame_pkg::*;

    logic [BAUD_CNT_W-1:0] cnt_q;
    logic [DIV_FRAC_W-1:0] acc_q;
    logic stretch_q;
    logic [BAUD_CNT_W-1:0] target;
    logic [DIV_FRAC_W:0] acc_sum;

    // Period of one bit is integer+1 ticks, plus one on fraction carry
    assign target = {1'b0, i_div_int} + {{(BAUD_CNT_W-1){1'b0}}, stretch_q}; // [R13]
    assign acc_sum = {1'b0, acc_q} + {1'b0, i_div_frac}; // [R12]
    assign o_bit_end = i_lf_tick && !i_restart && (cnt_q == target); // [R16]
    assign o_bit_mid = i_lf_tick && !i_restart && (cnt_q == (target >> 1)); // [R16]

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || i_restart) begin
            cnt_q <= CNT_RESET;
        end else if (o_bit_end) begin
            cnt_q <= CNT_RESET;
        end else if (i_lf_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Accumulator keeps its residue across frames so the rate averages out
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            acc_q <= ACC_RESET;
            stretch_q <= 1'b0;
        end else if (o_bit_end) begin
            acc_q <= acc_sum[DIV_FRAC_W-1:0]; // [R17]
            stretch_q <= acc_sum[DIV_FRAC_W]; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    bit_end_tick_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R16]
        o_bit_end |-> i_lf_tick)
        else $error("bit end outside a module clock tick");

    frac_carry_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R17]
        o_bit_end |=> stretch_q == ($past(acc_sum) > 6'h1f))
        else $error("fraction overflow did not stretch next bit");

    bit_period_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R13]
        (o_bit_end && !$past(i_restart)) |-> cnt_q == {1'b0, i_div_int} + stretch_q)
        else $error("bit period differs from divider");
endmodule : uart_baud_gen

// >>> uart_frame_core.sv
// Frame transmitter and receiver with parity, inversion and fractional baud
`timescale 1ns/10ps
module uart_frame_core #(
    parameter int DATA_BITS_MAX = 9
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Low-frequency module clock pin
    input wire logic i_low_freq_module_clock,
    // Frame format controls
    input wire logic i_data_width_9,
    input wire logic i_stop_count_sel,
    input wire logic [1:0] i_parity_mode,
    input wire logic i_line_invert,
    input wire logic [uart_frame_pkg::DIV_W-1:0] i_baud_divider,
    input wire logic i_rx_enable,
    // Transmit request
    input wire logic i_tx_valid,
    input wire logic [uart_frame_pkg::WORD_W-1:0] i_tx_data,
    output logic o_tx_ready,
    // Serial line
    output logic o_txd,
    input wire logic i_rxd,
    // Receive result
    output logic o_rx_valid,
    output logic [uart_frame_pkg::WORD_W-1:0] o_rx_data,
    output logic o_rx_parity_err,
    output logic o_rx_frame_err
);
    import uart_frame_pkg::*;

    // Word, shifter and index widths are sized for exactly nine data bits
    if (DATA_BITS_MAX != WORD_W) begin : gen_bad_width
        $error("DATA_BITS_MAX must be 9");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and module clock tick
    logic [1:0] lf_sync_q;
    logic lf_prev_q;
    logic [1:0] rxd_sync_q;
    logic lf_tick;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            lf_sync_q <= 2'h0;
            lf_prev_q <= 1'b0;
            rxd_sync_q <= 2'h3;
        end else begin
            lf_sync_q <= {lf_sync_q[0], i_low_freq_module_clock};
            lf_prev_q <= lf_sync_q[1];
            rxd_sync_q <= {rxd_sync_q[0], i_rxd};
        end
    end

    // Only rising edges of the slow clock move the frame logic
    assign lf_tick = lf_sync_q[1] && !lf_prev_q; // [R16]

    logic [DIV_INT_W-1:0] div_int;
    logic [DIV_FRAC_W-1:0] div_frac;
    assign div_int = i_baud_divider[DIV_INT_HI:DIV_INT_LO]; // [R14] [R15]
    assign div_frac = i_baud_divider[DIV_FRAC_HI:DIV_FRAC_LO]; // [R14]

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    tx_state_type tx_st_q;
    logic [WORD_W-1:0] tx_sh_q;
    logic [WORD_W-1:0] tx_word_q;
    logic [IDX_W-1:0] tx_idx_q;
    logic [IDX_W-1:0] tx_last_q;
    logic tx_par_en_q;
    logic tx_odd_q;
    logic tx_par_q;
    logic tx_stop2_q;
    logic tx_stop_idx_q;
    logic tx_load;
    logic tx_end;
    logic tx_bit;
    logic txd_q;
    logic [WORD_W-1:0] tx_masked;

    assign o_tx_ready = (tx_st_q == TX_IDLE);
    assign tx_load = i_tx_valid && o_tx_ready;
    assign tx_masked = i_data_width_9 ? i_tx_data : {1'b0, i_tx_data[WORD_W-2:0]};

    uart_baud_gen tx_baud (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_lf_tick(lf_tick),
        .i_restart(tx_load),
        .i_div_int(div_int),
        .i_div_frac(div_frac),
        .o_bit_mid(),
        .o_bit_end(tx_end)
    );

    // Width, parity and stop count are latched per frame; inversion and divider act live
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_word_q <= WORD_RESET;
            tx_last_q <= LAST_IDX_8;
            tx_par_en_q <= 1'b0;
            tx_odd_q <= 1'b0;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
        end else if (tx_load) begin
            tx_word_q <= tx_masked;
            tx_last_q <= i_data_width_9 ? LAST_IDX_9 : LAST_IDX_8; // [R05] [R02]
            tx_par_en_q <= i_parity_mode[1]; // [R11] [R05]
            tx_odd_q <= (i_parity_mode == PAR_ODD); // [R11]
            tx_par_q <= (^tx_masked) ^ (i_parity_mode == PAR_ODD); // [R09] [R10]
            tx_stop2_q <= i_stop_count_sel; // [R04] [R05]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_st_q <= TX_IDLE;
            tx_idx_q <= 4'h0;
            tx_stop_idx_q <= 1'b0;
            tx_sh_q <= WORD_RESET;
        end else if (tx_load) begin
            tx_st_q <= TX_START; // [R01]
            tx_sh_q <= tx_masked;
        end else if (tx_end) begin
            case (tx_st_q)
                TX_START: begin
                    tx_st_q <= TX_DATA;
                    tx_idx_q <= 4'h0;
                end
                TX_DATA: begin
                    tx_sh_q <= tx_sh_q >> 1; // [R03]
                    tx_idx_q <= tx_idx_q + 4'h1;
                    if (tx_idx_q == tx_last_q) begin
                        tx_st_q <= tx_par_en_q ? TX_PARITY : TX_STOP; // [R02] [R11]
                        tx_stop_idx_q <= 1'b0;
                    end
                end
                TX_PARITY: begin
                    tx_st_q <= TX_STOP;
                end
                TX_STOP: begin
                    if (tx_stop2_q && !tx_stop_idx_q) begin
                        tx_stop_idx_q <= 1'b1; // [R04]
                    end else begin
                        tx_st_q <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (tx_st_q)
            TX_START: tx_bit = 1'b0; // [R01]
            TX_DATA: tx_bit = tx_sh_q[0]; // [R03]
            TX_PARITY: tx_bit = tx_par_q; // [R09]
            default: tx_bit = 1'b1; // [R04]
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            txd_q <= 1'b1;
        end else begin
            txd_q <= tx_bit ^ i_line_invert; // [R07]
        end
    end
    assign o_txd = txd_q;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    rx_state_type rx_st_q;
    logic rx_line;
    logic rx_prev_q;
    logic rx_start;
    logic rx_mid;
    logic [WORD_W-1:0] rx_sh_q;
    logic [IDX_W-1:0] rx_idx_q;
    logic [IDX_W-1:0] rx_last_q;
    logic rx_w9_q;
    logic rx_par_en_q;
    logic rx_odd_q;
    logic rx_pbit_q;
    logic rx_stop2_q;
    logic rx_stop_idx_q;
    logic rx_ferr_q;
    logic rx_done;

    // Inversion is applied live; changing it mid-frame corrupts that frame
    assign rx_line = rxd_sync_q[1] ^ i_line_invert; // [R07] [R08]
    assign rx_start = lf_tick && (rx_st_q == RX_IDLE) && i_rx_enable && rx_prev_q && !rx_line;
    assign rx_done = rx_mid && (rx_st_q == RX_STOP) && !(rx_stop2_q && !rx_stop_idx_q);

    uart_baud_gen rx_baud (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_lf_tick(lf_tick),
        .i_restart(rx_start),
        .i_div_int(div_int),
        .i_div_frac(div_frac),
        .o_bit_mid(rx_mid),
        .o_bit_end()
    );

    // Idle level sampled on each tick to find the start edge
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_prev_q <= 1'b1;
        end else if (lf_tick) begin
            rx_prev_q <= rx_line; // [R16]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_last_q <= LAST_IDX_8;
            rx_w9_q <= 1'b0;
            rx_par_en_q <= 1'b0;
            rx_odd_q <= 1'b0;
            rx_stop2_q <= 1'b0;
        end else if (rx_start) begin
            rx_last_q <= i_data_width_9 ? LAST_IDX_9 : LAST_IDX_8; // [R05]
            rx_w9_q <= i_data_width_9;
            rx_par_en_q <= i_parity_mode[1]; // [R11]
            rx_odd_q <= (i_parity_mode == PAR_ODD);
            rx_stop2_q <= i_stop_count_sel; // [R04]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !i_rx_enable) begin
            rx_st_q <= RX_IDLE;
            rx_idx_q <= 4'h0;
            rx_sh_q <= WORD_RESET;
            rx_pbit_q <= 1'b0;
            rx_stop_idx_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else if (rx_start) begin
            rx_st_q <= RX_START;
            rx_ferr_q <= 1'b0;
        end else if (rx_mid) begin
            case (rx_st_q)
                RX_START: begin
                    // A start bit gone high at mid-bit was a glitch
                    rx_st_q <= rx_line ? RX_IDLE : RX_DATA; // [R01]
                    rx_idx_q <= 4'h0;
                end
                RX_DATA: begin
                    rx_sh_q <= {rx_line, rx_sh_q[WORD_W-1:1]}; // [R03]
                    rx_idx_q <= rx_idx_q + 4'h1;
                    if (rx_idx_q == rx_last_q) begin
                        rx_st_q <= rx_par_en_q ? RX_PARITY : RX_STOP; // [R02]
                        rx_stop_idx_q <= 1'b0;
                    end
                end
                RX_PARITY: begin
                    rx_pbit_q <= rx_line; // [R09]
                    rx_st_q <= RX_STOP;
                end
                RX_STOP: begin
                    rx_ferr_q <= rx_ferr_q || !rx_line; // [R04]
                    if (rx_stop2_q && !rx_stop_idx_q) begin
                        rx_stop_idx_q <= 1'b1;
                    end else begin
                        rx_st_q <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    logic [WORD_W-1:0] rx_word;
    assign rx_word = rx_w9_q ? rx_sh_q : {1'b0, rx_sh_q[WORD_W-1:1]};

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= WORD_RESET;
            o_rx_parity_err <= 1'b0;
            o_rx_frame_err <= 1'b0;
        end else begin
            o_rx_valid <= rx_done;
            if (rx_done) begin
                o_rx_data <= rx_word;
                o_rx_parity_err <= rx_par_en_q && ((^rx_word) ^ rx_pbit_q ^ rx_odd_q); // [R10]
                o_rx_frame_err <= rx_ferr_q || !rx_line;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    start_level_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R01]
        tx_st_q == TX_START |=> o_txd == $past(i_line_invert))
        else $error("start bit not at active low level");

    stop_level_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R04]
        tx_st_q == TX_STOP |=> o_txd == !$past(i_line_invert))
        else $error("stop bit not at idle level");

    lsb_first_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R03]
        (tx_st_q == TX_DATA) |-> tx_sh_q[0] == tx_word_q[tx_idx_q])
        else $error("data bit order is not LSB first");

    parity_value_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R10]
        tx_st_q == TX_PARITY |-> tx_par_q == ((^tx_word_q) ^ tx_odd_q))
        else $error("transmitted parity wrong");

    no_parity_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R11]
        (tx_st_q == TX_DATA && tx_end && tx_idx_q == tx_last_q && !tx_par_en_q)
        |=> tx_st_q == TX_STOP)
        else $error("parity bit sent while parity off");

    data_count_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R02]
        (tx_st_q == TX_DATA && tx_end && tx_idx_q != tx_last_q) |=> tx_st_q == TX_DATA)
        else $error("data phase ended early");

    two_stops_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R04]
        (tx_st_q == TX_STOP && tx_end && tx_stop2_q && !tx_stop_idx_q)
        |=> tx_st_q == TX_STOP && tx_stop_idx_q)
        else $error("second stop bit skipped");

    rx_parity_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R09]
        rx_done ##1 o_rx_valid |-> o_rx_parity_err ==
            (rx_par_en_q && ((^o_rx_data) ^ rx_pbit_q ^ rx_odd_q)))
        else $error("receive parity check wrong");

    tx_cover_c: cover property (@(posedge i_mclk) tx_st_q == TX_STOP ##1 tx_st_q == TX_IDLE);
    rx_cover_c: cover property (@(posedge i_mclk) o_rx_valid && !o_rx_parity_err);
    perr_cover_c: cover property (@(posedge i_mclk) o_rx_valid && o_rx_parity_err);
    inv_cover_c: cover property (@(posedge i_mclk) o_rx_valid && i_line_invert);
endmodule : uart_frame_core

// >>> uart_remote_model.sv
// Remote serial party that sends frames to the block and decodes its output
`timescale 1ns/10ps
module uart_remote_model #(
    parameter int BIT_CYC = 32
) (
    // Clock and line polarity
    input wire logic i_mclk,
    input wire logic i_line_invert,
    // Serial lines
    input wire logic i_txd,
    output logic o_rxd
);
    logic lvl = 1'b1;

    // Whole frame and idle level flip with the shared polarity setting
    assign o_rxd = lvl ^ i_line_invert;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Frame vector is built by the caller in the agreed format, bit 0 first
    task automatic send_frame(input logic [13:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge i_mclk);
            lvl = bits[i]; // Start, data LSB first, parity, stops
            repeat (BIT_CYC - 1) @(negedge i_mclk);
        end
        @(negedge i_mclk);
        lvl = 1'b1;
    endtask : send_frame

    ////////////////////////////////////////////////////////////////////////////////////////
    // Samples at mid-bit, so tick jitter of the sender is tolerated
    task automatic recv_frame(input int n, output logic [13:0] bits);
        int k;
        k = 0;
        bits = '0;
        @(negedge i_mclk);
        while ((i_txd ^ i_line_invert) !== 1'b0 && k < 4000) begin
            @(negedge i_mclk);
            k++;
        end
        repeat (BIT_CYC / 2) @(negedge i_mclk);
        for (int i = 0; i < n; i++) begin
            bits[i] = i_txd ^ i_line_invert;
            repeat (BIT_CYC) @(negedge i_mclk);
        end
    endtask : recv_frame
endmodule : uart_remote_model

// >>> lowpower_uart_frame_baud_tb_top.sv
// Self-checking bench for the frame format and fractional baud block
`timescale 1ns/10ps
module lowpower_uart_frame_baud_tb_top;
    import uart_frame_pkg::*;
    // Divider integer 3 gives four ticks of 80 ns per bit
    localparam int BIT_CYC = 32;
    logic mclk, resetn, lf_clk, w9, stop2, line_invert, rx_en, tx_valid;
    logic [1:0] par;
    logic [DIV_W-1:0] div;
    logic [WORD_W-1:0] tx_data, rx_data;
    logic tx_ready, txd, rxd, rx_valid, par_err, frm_err;
    int n_fail, n_compared, cyc;
    // Entries: {w9, stop2, parity[1:0], invert, data[8:0]}
    logic [13:0] tbl [6] = '{14'h00a5, 14'h393c, 14'h0c0f, 14'h165a, 14'h2fff, 14'h0881};

    uart_frame_core #(.DATA_BITS_MAX(9)) dut (
        .i_mclk(mclk), .i_resetn(resetn), .i_low_freq_module_clock(lf_clk),
        .i_data_width_9(w9), .i_stop_count_sel(stop2), .i_parity_mode(par),
        .i_line_invert(line_invert), .i_baud_divider(div), .i_rx_enable(rx_en),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
        .o_txd(txd), .i_rxd(rxd), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rx_parity_err(par_err), .o_rx_frame_err(frm_err)
    );

    uart_remote_model #(.BIT_CYC(BIT_CYC)) remote (
        .i_mclk(mclk), .i_line_invert(line_invert), .i_txd(txd), .o_rxd(rxd)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Fast stand-in for the low-frequency clock keeps frames short
    initial begin
        lf_clk = 1'b0;
        forever #40 lf_clk = ~lf_clk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [13:0] frame(input logic [8:0] d, output int n);
        logic [13:0] v;
        int nd;
        nd = w9 ? 9 : 8;
        v = '1;
        v[0] = 1'b0; // One low start bit
        for (int i = 0; i < nd; i++) v[1 + i] = d[i]; // LSB first
        n = 1 + nd;
        if (par[1]) begin
            v[n] = par[0] ^ (w9 ? ^d : ^d[7:0]); // Even or odd count of ones
            n++;
        end
        n = n + (stop2 ? 2 : 1); // High stop bits
        return v;
    endfunction : frame

    task automatic cfg(input logic [4:0] c);
        @(negedge mclk);
        rx_en = 1'b0; // Receiver off while polarity changes
        {w9, stop2, par, line_invert} = c;
        repeat (8) @(negedge mclk);
        rx_en = 1'b1;
        repeat (BIT_CYC) @(negedge mclk);
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic do_tx(input logic [8:0] d);
        logic [13:0] exp;
        logic [13:0] got;
        int n;
        exp = frame(d, n) & ((14'h0001 << n) - 14'h0001);
        @(negedge mclk);
        chk("txd idle", {13'h0, ~line_invert}, {13'h0, txd});
        fork
            remote.recv_frame(n, got);
            begin
                tx_valid = 1'b1;
                tx_data = d;
                @(negedge mclk);
                tx_valid = 1'b0;
                chk("tx busy", 14'h0000, {13'h0, tx_ready});
            end
        join
        chk("tx frame", exp, got);
    endtask : do_tx

    task automatic do_rx(input logic [8:0] d, input logic pe, input logic fe);
        logic [13:0] v;
        int n;
        int ns;
        logic seen;
        seen = 1'b0;
        ns = stop2 ? 2 : 1;
        v = frame(d, n);
        if (pe) v[n - ns - 1] = ~v[n - ns - 1];
        if (fe) v[n - 1] = ~v[n - 1];
        fork
            remote.send_frame(v, n);
            repeat (n * BIT_CYC + 40) begin
                @(negedge mclk);
                if (rx_valid === 1'b1) seen = 1'b1;
            end
        join
        chk("rx valid", {13'h0, rx_en}, {13'h0, seen});
        if (seen) begin
            chk("rx data", {5'h00, w9 & d[8], d[7:0]}, {5'h00, rx_data});
            chk("rx parity err", {13'h0, pe}, {13'h0, par_err});
            chk("rx frame err", {13'h0, fe}, {13'h0, frm_err});
        end
    endtask : do_rx

    // Start-to-ready length of a ten-bit frame against the ideal tick count, 8 cycles a tick;
    // the partial first tick and a carry left for the next frame each cost up to one tick
    task automatic measure(input logic [DIV_W-1:0] dv, input int ticks);
        int c;
        c = 0;
        @(negedge mclk);
        div = dv;
        tx_valid = 1'b1;
        tx_data = 9'h055;
        @(negedge mclk);
        tx_valid = 1'b0;
        while (tx_ready !== 1'b1 && c < 1000) begin
            @(negedge mclk);
            c++;
        end
        chk("frame length", 14'h0001, {13'h0, (c >= ticks * 8 - 16 && c <= ticks * 8 + 8)});
        repeat (BIT_CYC) @(negedge mclk);
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        resetn = 1'b0;
        {w9, stop2, par, line_invert} = 5'h00;
        rx_en = 1'b1;
        tx_valid = 1'b0;
        tx_data = 9'h000;
        div = 15'h0300;
        repeat (5) @(negedge mclk);
        chk("reset outputs", 14'h0003, {rx_data, par_err, frm_err, rx_valid, tx_ready, txd});
        resetn = 1'b1;
        repeat (5) @(negedge mclk);
        for (int k = 0; k < 6; k++) begin
            cfg(tbl[k][13:9]);
            do_tx(tbl[k][8:0]);
            do_rx(tbl[k][8:0], 1'b0, 1'b0);
        end
        do_rx(9'h0c3, 1'b1, 1'b0);
        do_rx(9'h03c, 1'b0, 1'b1);
        @(negedge mclk);
        rx_en = 1'b0;
        do_rx(9'h011, 1'b0, 1'b0);
        cfg(5'h00);
        measure(15'h0300, 40);
        measure(15'h0380, 45);
        report_and_stop();
    end
endmodule : lowpower_uart_frame_baud_tb_top
